// ===== design/iee_exception_entry.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Functional notes
// - interrupt entry aborts all younger instructions
// - entry saves resume address in return register
// - entry writes cause code into cause register
// - entry clears current user bit, kernel mode
// - entry clears current interrupt enable bit
// - next fetch after detection is exception vector
// - one vector for all but reset, translation miss
// - recognise interrupts only while the pipeline runs
// - synchronised lines: two flops, two cycle latency
// - direct lines: no synchroniser, one cycle latency
// - hardware saves no general registers on entry
// - four branch condition pins readable by branches
// - status holds software writable per-line mask
module iee_exception_entry #(
	parameter int N_SYNC   = iee_pkg::IEE_N_SYNC,
	parameter int N_DIRECT = iee_pkg::IEE_N_DIRECT,
	parameter int N_BRCOND = iee_pkg::IEE_N_BRCOND
) (
	// clock and reset
	input  wire logic                          core_clk_in,
	input  wire logic                          resetn_in,
	// interrupt and condition pins
	input  wire logic [N_SYNC-1:0]             sync_int_in,
	input  wire logic [N_DIRECT-1:0]           direct_int_in,
	input  wire logic [N_BRCOND-1:0]           branch_condition_in,
	output logic      [N_BRCOND-1:0]           branch_condition_out,
	output logic                               system_clock_out,
	// pipeline
	input  wire logic                          pipe_run_in,
	input  wire logic [31:0]                   resume_pc_in,
	input  wire logic                          exc_req_in,
	input  wire logic [4:0]                    exc_code_in,
	input  wire logic                          exc_utm_in,
	input  wire logic                          rfe_in,
	output logic                               abort_younger_out,
	output logic                               vector_fetch_out,
	output logic      [31:0]                   vector_addr_out,
	// axi4-lite slave
	input  wire logic [iee_pkg::IEE_AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic      [1:0]                    s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [iee_pkg::IEE_AXI_AW-1:0] s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic      [31:0]                   s_axi_rdata,
	output logic      [1:0]                    s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// interrupt
	output logic                               irq_out
);
	import iee_pkg::*;

	localparam int N_LINES = N_SYNC + N_DIRECT;

	if (N_LINES > IEE_MASK_W || N_BRCOND < 1 || N_BRCOND > 32) begin : g_chk
		$error("iee_exception_entry: line counts out of range");
	end

	typedef enum logic [1:0] {
		IEE_W_IDLE = 2'b01,
		IEE_W_RESP = 2'b10
	} iee_wr_e;

	typedef enum logic [1:0] {
		IEE_R_IDLE = 2'b01,
		IEE_R_RESP = 2'b10
	} iee_rd_e;

	typedef struct packed {
		logic [31:0]         status;
		logic [4:0]          code;
		logic [31:0]         ret_addr;
		logic [1:0]          evt;
		logic [1:0]          evt_mask;
		logic [N_BRCOND-1:0] brcond;
		logic                sys_clk;
		logic                boot;
		logic                aw_got;
		logic [7:0]          aw_addr;
		logic                w_got;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		iee_wr_e             wst;
		logic [1:0]          bresp;
		iee_rd_e             rst;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} iee_state_s;

	////////////////////////////////////////////////////////////////////////////////
	// reset release and line synchronisers

	logic               rst_meta;
	logic               rst_n;
	logic [N_LINES-1:0] pend;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	iee_int_sync #(
		.N_SYNC   (N_SYNC),
		.N_DIRECT (N_DIRECT)
	) u_sync (
		.clk_in        (core_clk_in),
		.rst_n_in      (rst_n),
		.sync_int_in   (sync_int_in),
		.direct_int_in (direct_int_in),
		.pend_out      (pend)
	);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		unique case ({addr[7:2], 2'b00})
			IEE_OFF_STATUS:   reg_index = 3'h0;
			IEE_OFF_CAUSE:    reg_index = 3'h1;
			IEE_OFF_RET_ADDR: reg_index = 3'h2;
			IEE_OFF_EVT_STAT: reg_index = 3'h3;
			IEE_OFF_EVT_MASK: reg_index = 3'h4;
			IEE_OFF_BRCOND:   reg_index = 3'h5;
			default:          reg_index = IEE_IDX_NONE;
		endcase
	endfunction : reg_index

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
	                                           input logic [3:0] strb);
		merge_strb = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge_strb[8*i +: 8] = new_v[8*i +: 8];
			end
		end
	endfunction : merge_strb

	////////////////////////////////////////////////////////////////////////////////
	// recognition

	iee_state_s         st;
	iee_state_s         next_st;
	logic [N_LINES-1:0] masked;
	logic               int_take;
	logic               exc_take;
	logic               take;
	logic [31:0]        cause_word;

	assign masked     = pend & st.status[IEE_ST_MASK_LSB +: N_LINES];
	// stalls hold the line pending; boot cycle is not a running pipeline
	assign int_take   = pipe_run_in && !st.boot && !exc_req_in
	                    && st.status[IEE_ST_IE_CUR] && (|masked);
	assign exc_take   = pipe_run_in && !st.boot && exc_req_in;
	assign take       = int_take || exc_take;
	assign cause_word = {{(32 - IEE_CA_PEND_LSB - N_LINES){1'b0}}, pend, 1'b0, st.code, 2'b00};

	assign abort_younger_out = take;
	assign vector_fetch_out  = take || st.boot;
	always_comb begin
		if (st.boot) begin
			vector_addr_out = IEE_VEC_RESET;
		end else if (exc_take && exc_utm_in) begin
			vector_addr_out = IEE_VEC_UTM;
		end else begin
			vector_addr_out = IEE_VEC_GENERAL;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	logic [2:0] wr_idx;
	logic [2:0] rd_idx;
	logic       aw_hs;
	logic       w_hs;
	logic       ar_hs;

	assign s_axi_awready = !st.aw_got && (st.wst == IEE_W_IDLE);
	assign s_axi_wready  = !st.w_got && (st.wst == IEE_W_IDLE);
	assign s_axi_bvalid  = (st.wst == IEE_W_RESP);
	assign s_axi_arready = (st.rst == IEE_R_IDLE);
	assign s_axi_rvalid  = (st.rst == IEE_R_RESP);
	assign aw_hs         = s_axi_awvalid && s_axi_awready;
	assign w_hs          = s_axi_wvalid && s_axi_wready;
	assign ar_hs         = s_axi_arvalid && s_axi_arready;
	assign wr_idx        = reg_index(st.aw_addr);
	assign rd_idx        = reg_index(s_axi_araddr);

	always_comb begin
		logic [1:0] ev_set;
		logic [1:0] ev_clr;
		ev_set          = '0;
		ev_clr          = '0;
		next_st         = st;
		next_st.boot    = 1'b0;
		next_st.sys_clk = !st.sys_clk;
		next_st.brcond  = branch_condition_in;
		// write channel
		if (aw_hs) begin
			next_st.aw_got  = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (w_hs) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		unique case (st.wst)
			IEE_W_IDLE: begin
				if (st.aw_got && st.w_got) begin
					next_st.aw_got = 1'b0;
					next_st.w_got  = 1'b0;
					next_st.wst    = IEE_W_RESP;
					next_st.bresp  = (wr_idx == IEE_IDX_NONE) ? IEE_RESP_DECERR : IEE_RESP_OKAY;
					if (wr_idx == 3'h0) begin
						next_st.status = merge_strb(st.status, st.wdata, st.wstrb);
					end
					if (wr_idx == 3'h4) begin
						next_st.evt_mask = st.wstrb[0] ? st.wdata[1:0] : st.evt_mask;
					end
				end
			end
			IEE_W_RESP: begin
				if (s_axi_bready) begin
					next_st.wst = IEE_W_IDLE;
				end
			end
		endcase
		// read channel; a read of the event status clears it
		unique case (st.rst)
			IEE_R_IDLE: begin
				if (ar_hs) begin
					next_st.rst   = IEE_R_RESP;
					next_st.rresp = IEE_RESP_OKAY;
					unique case (rd_idx)
						3'h0: next_st.rdata = st.status;
						3'h1: next_st.rdata = cause_word;
						3'h2: next_st.rdata = st.ret_addr;
						3'h3: begin
							next_st.rdata = {30'h0000_0000, st.evt};
							ev_clr        = st.evt;
						end
						3'h4: next_st.rdata = {30'h0000_0000, st.evt_mask};
						3'h5: next_st.rdata = {{(32 - N_BRCOND){1'b0}}, st.brcond};
						default: begin
							next_st.rdata = 32'h0000_0000;
							next_st.rresp = IEE_RESP_DECERR;
						end
					endcase
				end
			end
			IEE_R_RESP: begin
				if (s_axi_rready) begin
					next_st.rst = IEE_R_IDLE;
				end
			end
		endcase
		// return from exception pops the mode/enable stack
		if (rfe_in && pipe_run_in && !take) begin
			next_st.status[3:0] = st.status[5:2];
		end
		// entry beats a software write in the same cycle; only these registers change
		if (take) begin
			next_st.ret_addr = resume_pc_in;
			next_st.code     = int_take ? IEE_CODE_INT : exc_code_in;
			next_st.status[IEE_ST_STACK_W-1:0] = {st.status[3:0], 2'b00};
			ev_set[IEE_EV_INT] = int_take;
			ev_set[IEE_EV_EXC] = exc_take;
		end
		// set wins over the read clear
		next_st.evt = (st.evt & ~ev_clr) | ev_set;
	end

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			st        <= '0;
			st.status <= IEE_ST_RESET;
			st.boot   <= 1'b1;
			st.wst    <= IEE_W_IDLE;
			st.rst    <= IEE_R_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign branch_condition_out = st.brcond;
	assign system_clock_out     = st.sys_clk;
	assign s_axi_bresp          = st.bresp;
	assign s_axi_rdata          = st.rdata;
	assign s_axi_rresp          = st.rresp;
	assign irq_out              = |(st.evt & st.evt_mask);

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n);

	AST_ABORT_WHEN_PENDING: assert property (
		pipe_run_in && !st.boot && st.status[IEE_ST_IE_CUR] && (|masked) |-> abort_younger_out)
		else $error("enabled pending line did not abort the pipeline");
	AST_RET_ADDR_SAVED: assert property (
		abort_younger_out |=> st.ret_addr == $past(resume_pc_in))
		else $error("return address not saved on entry");
	AST_CAUSE_INT: assert property (
		int_take |=> st.code == IEE_CODE_INT)
		else $error("cause code not interrupt after entry");
	AST_KERNEL_ENTRY: assert property (
		abort_younger_out |=> !st.status[IEE_ST_USER_CUR]
		&& st.status[IEE_ST_USER_PREV] == $past(st.status[IEE_ST_USER_CUR]))
		else $error("mode bits wrong after entry");
	AST_IE_CLEARED: assert property (
		abort_younger_out |=> !st.status[IEE_ST_IE_CUR] ##0 !int_take)
		else $error("interrupts still enabled after entry");
	AST_VECTOR_GENERAL: assert property (
		int_take |-> vector_fetch_out && vector_addr_out == IEE_VEC_GENERAL)
		else $error("interrupt did not fetch the general vector");
	AST_VECTOR_UTM: assert property (
		exc_take && exc_utm_in |-> vector_addr_out == IEE_VEC_UTM)
		else $error("translation miss used the wrong vector");
	AST_NO_TAKE_STALLED: assert property (
		!pipe_run_in |-> !abort_younger_out)
		else $error("interrupt recognised during a stall");
	AST_BRCOND_PASS: assert property (
		##1 branch_condition_out == $past(branch_condition_in))
		else $error("branch condition outputs lag wrongly");
	AST_MASK_BLOCKS: assert property (
		(masked == '0) || !st.status[IEE_ST_IE_CUR] |-> !int_take)
		else $error("masked or disabled line was taken");

	COV_INT_TAKEN: cover property (int_take ##1 !st.status[IEE_ST_IE_CUR]);
	COV_UTM_TAKEN: cover property (exc_take && exc_utm_in);
	COV_STALL_THEN_TAKE: cover property (!pipe_run_in && (|masked) ##1 int_take);
	COV_EVT_READ: cover property (irq_out ##[1:20] !irq_out);
endmodule : iee_exception_entry

// ===== design/iee_pkg.sv
package iee_pkg;
	// line counts and bus widths
	localparam int          IEE_N_SYNC       = 3;
	localparam int          IEE_N_DIRECT     = 3;
	localparam int          IEE_N_BRCOND     = 4;
	localparam int          IEE_MASK_W       = 8;
	localparam int          IEE_AXI_AW       = 8;
	// register byte offsets
	localparam logic [7:0]  IEE_OFF_STATUS   = 8'h00;
	localparam logic [7:0]  IEE_OFF_CAUSE    = 8'h04;
	localparam logic [7:0]  IEE_OFF_RET_ADDR = 8'h08;
	localparam logic [7:0]  IEE_OFF_EVT_STAT = 8'h0c;
	localparam logic [7:0]  IEE_OFF_EVT_MASK = 8'h10;
	localparam logic [7:0]  IEE_OFF_BRCOND   = 8'h14;
	// status fields: current, previous and old mode/enable pairs, line mask
	localparam int          IEE_ST_IE_CUR    = 0;
	localparam int          IEE_ST_USER_CUR  = 1;
	localparam int          IEE_ST_IE_PREV   = 2;
	localparam int          IEE_ST_USER_PREV = 3;
	localparam int          IEE_ST_STACK_W   = 6;
	localparam int          IEE_ST_MASK_LSB  = 8;
	localparam logic [31:0] IEE_ST_RESET     = 32'h0000_0000;
	// cause fields
	localparam int          IEE_CA_CODE_LSB  = 2;
	localparam int          IEE_CA_PEND_LSB  = 8;
	localparam logic [4:0]  IEE_CODE_INT     = 5'h00;
	// event status bits
	localparam int          IEE_EV_INT       = 0;
	localparam int          IEE_EV_EXC       = 1;
	// vectors
	localparam logic [31:0] IEE_VEC_RESET    = 32'h0000_0000;
	localparam logic [31:0] IEE_VEC_UTM      = 32'h0000_0080;
	localparam logic [31:0] IEE_VEC_GENERAL  = 32'h0000_0100;
	// axi responses
	localparam logic [1:0]  IEE_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  IEE_RESP_DECERR  = 2'h3;
	// register index returned by the address decoder
	localparam logic [2:0]  IEE_IDX_NONE     = 3'h7;
endpackage : iee_pkg

// ===== design/iee_int_sync.sv
`timescale 1ns/10ps
module iee_int_sync #(
	parameter int N_SYNC   = iee_pkg::IEE_N_SYNC,
	parameter int N_DIRECT = iee_pkg::IEE_N_DIRECT
) (
	// clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         rst_n_in,
	// interrupt pins
	input  wire logic [N_SYNC-1:0]            sync_int_in,
	input  wire logic [N_DIRECT-1:0]          direct_int_in,
	// pending lines, direct lines above synchronised ones
	output logic      [N_SYNC+N_DIRECT-1:0]   pend_out
);
	import iee_pkg::*;

	if (N_SYNC < 1 || N_DIRECT < 1) begin : g_chk
		$error("iee_int_sync: each line group needs at least one line");
	end

	typedef struct packed {
		logic [N_SYNC-1:0]   meta;
		logic [N_SYNC-1:0]   sync;
		logic [N_DIRECT-1:0] direct;
	} iee_sync_s;

	iee_sync_s st;
	iee_sync_s next_st;

	// the first stage feeds only the second; direct lines get one sample flop only
	always_comb begin
		next_st        = st;
		next_st.meta   = sync_int_in;
		next_st.sync   = st.meta;
		next_st.direct = direct_int_in;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pend_out = {st.direct, st.sync};

	AST_SYNC_TWO_CYCLES: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		##2 pend_out[N_SYNC-1:0] == $past(sync_int_in, 2))
		else $error("synchronised line not two cycles behind its pin");

	AST_DIRECT_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		##1 pend_out[N_SYNC+N_DIRECT-1:N_SYNC] == $past(direct_int_in))
		else $error("direct line not one cycle behind its pin");
endmodule : iee_int_sync

// ===== dv/iee_irq_agent.sv
`timescale 1ns/10ps
module iee_irq_agent (
	// clock
	input  wire logic                              core_clk_in,
	// requests from the bench
	input  wire logic [iee_pkg::IEE_N_SYNC-1:0]   sync_req_in,
	input  wire logic [iee_pkg::IEE_N_DIRECT-1:0] direct_req_in,
	// interrupt pins
	output logic      [iee_pkg::IEE_N_SYNC-1:0]   sync_int_out,
	output logic      [iee_pkg::IEE_N_DIRECT-1:0] direct_int_out
);
	import iee_pkg::*;
	initial begin
		sync_int_out = '0;
		direct_int_out = '0;
	end
	// unrelated source: edges land mid-cycle, never on the core edge
	always @(posedge core_clk_in) sync_int_out <= #17 sync_req_in;
	// clocked off the core, so the unsynchronised pins only see clean levels
	always @(posedge core_clk_in) direct_int_out <= direct_req_in;
endmodule : iee_irq_agent

// ===== dv/test_interrupt_exception_entry.sv
`timescale 1ns/10ps
module test_interrupt_exception_entry;
	import iee_pkg::*;
	logic        core_clk_in = 1'b0, resetn_in = 1'b0, pipe_run_in = 1'b1;
	logic        exc_req_in = 1'b0, exc_utm_in = 1'b0, rfe_in = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [2:0]  sync_req = '0, direct_req = '0, sync_int_in, direct_int_in;
	logic [3:0]  branch_condition_in = '0, s_axi_wstrb = 4'hf, branch_condition_out;
	logic [4:0]  exc_code_in = '0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] resume_pc_in = '0, s_axi_wdata = '0, vector_addr_out, s_axi_rdata;
	logic        system_clock_out, abort_younger_out, vector_fetch_out, irq_out;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          compares = 0, miscompares = 0, cycles = 0, aborts = 0;

	always #25 core_clk_in = ~core_clk_in;

	iee_irq_agent agent (.core_clk_in, .sync_req_in(sync_req), .direct_req_in(direct_req),
		.sync_int_out(sync_int_in), .direct_int_out(direct_int_in));
	iee_exception_entry uut (.core_clk_in, .resetn_in, .sync_int_in, .direct_int_in, .branch_condition_in,
		.branch_condition_out, .system_clock_out, .pipe_run_in, .resume_pc_in, .exc_req_in, .exc_code_in,
		.exc_utm_in, .rfe_in, .abort_younger_out, .vector_fetch_out, .vector_addr_out, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_out);

	// counted mid-cycle, where the combinational pulse has settled
	always @(negedge core_clk_in) aborts += int'(abort_younger_out === 1'b1);
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	////////////////////////////////////////
	task automatic finish_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask : chk1

	task automatic irq_chk(input logic e);
		@(negedge core_clk_in);
		chk1("irq", e, irq_out);
		@(posedge core_clk_in);
	endtask : irq_chk
	////////////////////////////////////////
	// ready is sampled mid-cycle: it is stable there and equals its value at the next edge
	// valid drops only at the edge that took it, and bready/rready stay high between
	// transfers, so back-to-back calls never drive one signal twice in a time step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa, pw, hb, ta, tw;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		hb = 1'b0;
		while (!hb) begin
			@(negedge core_clk_in);
			hb = !pa && !pw && s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			ta = pa && s_axi_awready === 1'b1;
			tw = pw && s_axi_wready === 1'b1;
			@(posedge core_clk_in);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic pa, hr, ta;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		pa = 1'b1;
		hr = 1'b0;
		while (!hr) begin
			@(negedge core_clk_in);
			hr = !pa && s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			ta = pa && s_axi_arready === 1'b1;
			@(posedge core_clk_in);
			if (ta) s_axi_arvalid <= 1'b0;
			pa = pa && !ta;
		end
	endtask : axi_rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk("bresp", 32'(IEE_RESP_OKAY), 32'(r));
	endtask : wr

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		chk(nm, e, d);
	endtask : rd_chk
	////////////////////////////////////////
	task automatic boot_test;
		logic        seen;
		logic [31:0] va;
		seen = 1'b0;
		va = '1;
		repeat (2) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		repeat (5) begin
			@(negedge core_clk_in);
			if (vector_fetch_out === 1'b1 && !seen) va = vector_addr_out;
			if (vector_fetch_out === 1'b1) seen = 1'b1;
			@(posedge core_clk_in);
		end
		chk1("boot fetch", 1'b1, seen);
		chk("boot vector", IEE_VEC_RESET, va);
		rd_chk("status reset", IEE_OFF_STATUS, IEE_ST_RESET);
	endtask : boot_test

	task automatic brcond_test;
		logic sc;
		@(negedge core_clk_in);
		sc = system_clock_out;
		@(negedge core_clk_in);
		chk1("system_clock_output toggles", 1'b1, (sc ^ system_clock_out) === 1'b1);
		@(posedge core_clk_in);
		for (int i = 0; i < IEE_N_BRCOND; i++) begin
			branch_condition_in <= 4'h1 << i;
			@(posedge core_clk_in);
			@(negedge core_clk_in);
			chk("brcond", 32'h1 << i, 32'(branch_condition_out));
			@(posedge core_clk_in);
		end
		rd_chk("brcond reg", IEE_OFF_BRCOND, 32'h0000_0008);
	endtask : brcond_test

	// lines below IEE_N_SYNC are synchronised, the rest direct; the extra flop costs one edge
	task automatic take_test(input int line);
		logic [31:0] m;
		int          k;
		m = 32'h1 << (IEE_ST_MASK_LSB + line);
		k = (line < IEE_N_SYNC) ? 3 : 2;
		wr(IEE_OFF_EVT_MASK, 32'h0000_0001);
		wr(IEE_OFF_STATUS, m | 32'h0000_0003);
		resume_pc_in <= 32'h0000_4000 + 32'(line * 4);
		if (line < IEE_N_SYNC) sync_req[line] <= 1'b1;
		else direct_req[line - IEE_N_SYNC] <= 1'b1;
		for (int i = 0; i < k + 2; i++) begin
			@(negedge core_clk_in);
			chk1("abort", i == k, abort_younger_out);
			chk1("fetch", i == k, vector_fetch_out);
			chk1("irq", i == k + 1, irq_out);
			if (i == k) chk("vector", IEE_VEC_GENERAL, vector_addr_out);
			@(posedge core_clk_in);
		end
		rd_chk("cause", IEE_OFF_CAUSE, (32'h1 << (IEE_CA_PEND_LSB + line)) |
			(32'(IEE_CODE_INT) << IEE_CA_CODE_LSB));
		sync_req <= '0;
		direct_req <= '0;
		rd_chk("ret addr", IEE_OFF_RET_ADDR, 32'h0000_4000 + 32'(line * 4));
		rd_chk("status", IEE_OFF_STATUS, m | 32'h0000_000c);
		rd_chk("events", IEE_OFF_EVT_STAT, 32'h0000_0001);
		irq_chk(1'b0);
	endtask : take_test

	task automatic stall_test;
		wr(IEE_OFF_STATUS, 32'h0000_0801);
		pipe_run_in <= 1'b0;
		direct_req[0] <= 1'b1;
		repeat (6) begin
			@(negedge core_clk_in);
			chk1("stalled abort", 1'b0, abort_younger_out);
			@(posedge core_clk_in);
		end
		pipe_run_in <= 1'b1;
		@(negedge core_clk_in);
		chk1("run abort", 1'b1, abort_younger_out);
		@(posedge core_clk_in);
		direct_req <= '0;
		rd_chk("events", IEE_OFF_EVT_STAT, 32'h0000_0001);
		// return from exception pops the mode/enable stack back
		rfe_in <= 1'b1;
		@(posedge core_clk_in);
		rfe_in <= 1'b0;
		rd_chk("rfe status", IEE_OFF_STATUS, 32'h0000_0801);
	endtask : stall_test

	task automatic mask_test;
		int n;
		n = aborts;
		direct_req[1] <= 1'b1;
		wr(IEE_OFF_STATUS, 32'h0000_0001);
		wr(IEE_OFF_STATUS, 32'h0000_1000);
		chk("masked takes", n, aborts);
		wr(IEE_OFF_STATUS, 32'h0000_1001);
		repeat (2) @(posedge core_clk_in);
		chk("unmasked takes", n + 1, aborts);
		direct_req <= '0;
		rd_chk("events", IEE_OFF_EVT_STAT, 32'h0000_0001);
	endtask : mask_test

	// other exceptions win with interrupts disabled; the first one uses its own vector
	task automatic exc_test;
		for (int u = 0; u < 2; u++) begin
			exc_req_in <= 1'b1;
			exc_utm_in <= (u == 0);
			exc_code_in <= 5'(u + 8);
			@(negedge core_clk_in);
			chk1("exc abort", 1'b1, abort_younger_out);
			chk("exc vector", (u == 0) ? IEE_VEC_UTM : IEE_VEC_GENERAL, vector_addr_out);
			chk1("irq masked", 1'b0, irq_out);
			@(posedge core_clk_in);
			exc_req_in <= 1'b0;
			@(posedge core_clk_in);
		end
		rd_chk("exc cause", IEE_OFF_CAUSE, 32'h0000_0024);
		wr(IEE_OFF_EVT_MASK, 32'h0000_0003);
		irq_chk(1'b1);
		rd_chk("events", IEE_OFF_EVT_STAT, 32'h0000_0002);
		irq_chk(1'b0);
	endtask : exc_test

	task automatic axi_test;
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(8'h18, 32'hffff_ffff, r);
		chk("unmapped bresp", 32'(IEE_RESP_DECERR), 32'(r));
		axi_rd(8'h18, d, r);
		chk("unmapped rresp", 32'(IEE_RESP_DECERR), 32'(r));
		chk("unmapped rdata", 32'h0000_0000, d);
		wr(IEE_OFF_RET_ADDR, 32'hffff_ffff);
		rd_chk("ret addr ro", IEE_OFF_RET_ADDR, 32'h0000_4014);
		rd_chk("event mask", IEE_OFF_EVT_MASK, 32'h0000_0003);
	endtask : axi_test
	////////////////////////////////////////
	initial begin
		boot_test();
		brcond_test();
		take_test(0);
		take_test(2);
		take_test(3);
		take_test(5);
		stall_test();
		mask_test();
		exc_test();
		axi_test();
		finish_test();
	end
endmodule : test_interrupt_exception_entry
